// *** pkg/dcs_cfg.svh ***
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define DCS_OFS_ENABLE      5'h00
`define DCS_OFS_FLAGS       5'h01
`define DCS_OFS_CTRL        5'h02
`define DCS_OFS_RXS_LO      5'h03
`define DCS_OFS_RXS_HI      5'h04
`define DCS_OFS_RXE_LO      5'h05
`define DCS_OFS_RXE_HI      5'h06
`define DCS_OFS_DST_LO      5'h07
`define DCS_OFS_DST_HI      5'h08
`define DCS_OFS_DND_LO      5'h09
`define DCS_OFS_DND_HI      5'h0A
`define DCS_OFS_DDS_LO      5'h0B
`define DCS_OFS_DDS_HI      5'h0C
`define DCS_OFS_RES_LO      5'h0D
`define DCS_OFS_RES_HI      5'h0E

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DCS_BIT_GIE         7
`define DCS_BIT_DONE_EN     5
`define DCS_BIT_DONE_FLAG   5
`define DCS_BIT_RUN         5
`define DCS_BIT_CSUM_SEL    4

// ---------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------
`define DCS_RST_BYTE        8'h00
`define DCS_RST_WORD        16'h0000
`define DCS_PAD_BYTE        8'h00
`define DCS_ADDR_W          13
`define DCS_REG_AW          5

`endif

// *** pkg/dcs_pkg.sv ***
package dcs_pkg;

  typedef enum logic [0:0] {
    DCS_IDLE = 1'b0,
    DCS_RUN  = 1'b1
  } dcs_state_t;

  typedef logic [15:0] dcs_word_t;

  // One's-complement add with end-around carry
  function automatic dcs_word_t dcs_oc_add(input dcs_word_t a, input dcs_word_t b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

endpackage

// *** pkg/dcs_sum_if.sv ***
interface dcs_sum_if;
  logic byte_vld;
  logic [7:0] byte_dat;
  logic byte_last;
  logic init;
  logic abort;
  logic done;
  logic [15:0] sum;

  modport src (output byte_vld, output byte_dat, output byte_last, output init,
    output abort, input done, input sum);
  modport acc (input byte_vld, input byte_dat, input byte_last, input init,
    input abort, output done, output sum);
endinterface

// *** hdl/dcs_walker.sv ***
`include "dcs_cfg.svh"

module dcs_walker
  import dcs_pkg::*;
#(
  parameter int ADDR_W = `DCS_ADDR_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic abort,
  input wire logic [ADDR_W-1:0] start_ptr,
  input wire logic [ADDR_W-1:0] end_ptr,
  input wire logic [ADDR_W-1:0] rx_start,
  input wire logic [ADDR_W-1:0] rx_end,
  output logic [ADDR_W-1:0] addr_r,
  output logic rd_r,
  output logic last_r
);

  logic active_r;
  logic [ADDR_W-1:0] src_r;
  logic is_last;

  assign is_last = (src_r == end_ptr);

  // ---------------------------------------------------------------
  // Source pointer, one byte per clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_r <= 1'b0;
      src_r <= '0;
    end
    else if (abort)
    begin
      active_r <= 1'b0;
    end
    else if (go)
    begin
      active_r <= 1'b1;
      src_r <= start_ptr;
    end
    else if (active_r)
    begin
      if (is_last)
        active_r <= 1'b0; // R04
      else if (src_r == rx_end)
        src_r <= rx_start; // R14
      else
        src_r <= src_r + {{(ADDR_W-1){1'b0}}, 1'b1}; // R09
    end
  end

  // ---------------------------------------------------------------
  // Read request toward buffer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_r <= '0;
      rd_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      addr_r <= src_r;
      rd_r <= active_r && !abort;
      last_r <= active_r && !abort && is_last;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wrap_reload: assert property ( // R14
    active_r && !abort && !go && !is_last && src_r == rx_end |=> src_r == $past(rx_start))
    else $error("source pointer did not reload at rx end");

  a_one_per_clk: assert property ( // R09
    active_r && !abort && !go && !is_last && src_r != rx_end |=> src_r == $past(src_r) + 1'b1)
    else $error("source pointer did not advance by one");

  a_stop_at_end: assert property ( // R04
    active_r && !abort && !go && is_last |=> !active_r ##1 !rd_r)
    else $error("walk continued past end pointer");

endmodule

// *** hdl/dcs_accum.sv ***
`include "dcs_cfg.svh"

module dcs_accum
  import dcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dcs_sum_if.acc s
);

  dcs_word_t acc_r;
  logic [7:0] hi_r;
  logic hi_have_r;
  logic fin_r;
  logic done_r;
  dcs_word_t sum_r;

  assign s.done = done_r;
  assign s.sum = sum_r;

  // ---------------------------------------------------------------
  // Word pairing and folding sum
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= `DCS_RST_WORD;
      hi_r <= `DCS_RST_BYTE;
      hi_have_r <= 1'b0;
      fin_r <= 1'b0;
    end
    else if (s.init || s.abort)
    begin
      acc_r <= `DCS_RST_WORD;
      hi_have_r <= 1'b0;
      fin_r <= 1'b0;
    end
    else
    begin
      fin_r <= 1'b0;
      if (s.byte_vld)
      begin
        if (!hi_have_r)
        begin
          if (s.byte_last)
          begin
            acc_r <= dcs_oc_add(acc_r, {s.byte_dat, `DCS_PAD_BYTE}); // R02
            fin_r <= 1'b1;
          end
          else
          begin
            hi_r <= s.byte_dat; // R01
            hi_have_r <= 1'b1;
          end
        end
        else
        begin
          acc_r <= dcs_oc_add(acc_r, {hi_r, s.byte_dat}); // R01 R03
          hi_have_r <= 1'b0;
          fin_r <= s.byte_last;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Final inversion
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_r <= 1'b0;
      sum_r <= `DCS_RST_WORD;
    end
    else
    begin
      done_r <= fin_r && !s.abort;
      if (fin_r)
        sum_r <= ~acc_r; // R03
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_odd_tail;
    s.byte_vld && s.byte_last && !hi_have_r && !s.init && !s.abort;
  endsequence

  a_odd_pad: assert property ( // R02
    s_odd_tail |=> acc_r == dcs_oc_add($past(acc_r), {$past(s.byte_dat), 8'h00}))
    else $error("odd tail byte not padded with zero");

  a_final_invert: assert property ( // R03
    fin_r && !s.abort |=> done_r && sum_r == ~$past(acc_r))
    else $error("result is not the inverse of the sum");

  a_word_order: assert property ( // R01
    s.byte_vld && hi_have_r && !s.init && !s.abort
    |=> acc_r == dcs_oc_add($past(acc_r), {$past(hi_r), $past(s.byte_dat)}))
    else $error("byte pair not combined big-endian");

endmodule

// *** hdl/dcs_top.sv ***
// Notes on behaviour
// R01: First byte is word high half
// R02: Odd count pads final low byte zero
// R03: End-around carry sum, result inverted
// R04: Range covers start through end inclusive
// R05: Select plus run bit starts checksum
// R06: Finish clears run, sets flag, gated interrupt
// R07: Pointers untouched, no buffer writes
// R08: Result split into high and low registers
// R09: One buffer byte consumed per clock
// R10: Host clears flag, enables interrupt first
// R11: Host picks reachable end under wrapping
// R12: Host verifies embedded checksum by recompute
// R13: Pointers thirteen bits, high upper bits zero
// R14: Wrap to rx start after rx end
// R15: Clearing run cancels, sets done flag
// R16: Done flag sticky until host clears
// R17: Host leaves pointers alone while running
`include "dcs_cfg.svh"

module dcs_top
  import dcs_pkg::*;
#(
  parameter int ADDR_W = `DCS_ADDR_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`DCS_REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic irq_n,
  output logic busy
);

  localparam int HI_W = ADDR_W - 8;

  if (ADDR_W < 9 || ADDR_W > 15)
  begin : g_bad_width
    $error("dcs_top: ADDR_W must be 9 to 15");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] hi_byte(input logic [HI_W-1:0] v);
    return {{(16-ADDR_W){1'b0}}, v}; // R13
  endfunction

  function automatic logic is_wr(input logic [`DCS_REG_AW-1:0] ofs,
    input logic we, input logic [`DCS_REG_AW-1:0] a);
    return we && (a == ofs);
  endfunction

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] enable_r;
  logic flag_r;
  logic [7:0] ctrl_r;
  logic [7:0] rxs_lo_r, rxe_lo_r, dst_lo_r, dnd_lo_r, dds_lo_r;
  logic [HI_W-1:0] rxs_hi_r, rxe_hi_r, dst_hi_r, dnd_hi_r, dds_hi_r;
  logic [7:0] res_lo_r, res_hi_r;
  dcs_state_t state_r;
  dcs_state_t state_nxt;
  logic ctrl_wr;
  logic start_go;
  logic cancel;
  logic finish;
  logic rd_vld_r;
  logic rd_last_r;
  logic irq_n_r;
  logic [7:0] reg_rdata_r;
  logic [ADDR_W-1:0] walk_addr;
  logic walk_rd;
  logic walk_last;

  dcs_sum_if sif ();

  assign ctrl_wr = is_wr(`DCS_OFS_CTRL, reg_we, reg_addr);
  assign start_go = ctrl_wr && (state_r == DCS_IDLE) && reg_wdata[`DCS_BIT_RUN]
    && reg_wdata[`DCS_BIT_CSUM_SEL]; // R05
  assign cancel = ctrl_wr && (state_r == DCS_RUN) && !reg_wdata[`DCS_BIT_RUN]; // R15
  assign finish = (state_r == DCS_RUN) && sif.done;

  // ---------------------------------------------------------------
  // Operation state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      DCS_IDLE:
        if (start_go)
          state_nxt = DCS_RUN;
      DCS_RUN:
        if (cancel || sif.done)
          state_nxt = DCS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= DCS_IDLE;
    else
      state_r <= state_nxt;
  end

  // ---------------------------------------------------------------
  // Control and enables
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= `DCS_RST_BYTE;
    else
    begin
      if (ctrl_wr)
        ctrl_r <= reg_wdata;
      if (finish)
        ctrl_r[`DCS_BIT_RUN] <= 1'b0; // R06
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      enable_r <= `DCS_RST_BYTE;
    else if (is_wr(`DCS_OFS_ENABLE, reg_we, reg_addr))
      enable_r <= reg_wdata;
  end

  // Hardware set wins over host clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_r <= 1'b0;
    else if (finish || cancel)
      flag_r <= 1'b1; // R06 R15
    else if (is_wr(`DCS_OFS_FLAGS, reg_we, reg_addr))
      flag_r <= reg_wdata[`DCS_BIT_DONE_FLAG]; // R16
  end

  // ---------------------------------------------------------------
  // Pointers, written by host only
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxs_lo_r <= `DCS_RST_BYTE;
      rxe_lo_r <= `DCS_RST_BYTE;
      dst_lo_r <= `DCS_RST_BYTE;
      dnd_lo_r <= `DCS_RST_BYTE;
      dds_lo_r <= `DCS_RST_BYTE;
    end
    else
    begin
      if (is_wr(`DCS_OFS_RXS_LO, reg_we, reg_addr))
        rxs_lo_r <= reg_wdata;
      if (is_wr(`DCS_OFS_RXE_LO, reg_we, reg_addr))
        rxe_lo_r <= reg_wdata;
      if (is_wr(`DCS_OFS_DST_LO, reg_we, reg_addr))
        dst_lo_r <= reg_wdata;
      if (is_wr(`DCS_OFS_DND_LO, reg_we, reg_addr))
        dnd_lo_r <= reg_wdata;
      if (is_wr(`DCS_OFS_DDS_LO, reg_we, reg_addr))
        dds_lo_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxs_hi_r <= '0;
      rxe_hi_r <= '0;
      dst_hi_r <= '0;
      dnd_hi_r <= '0;
      dds_hi_r <= '0;
    end
    else
    begin
      if (is_wr(`DCS_OFS_RXS_HI, reg_we, reg_addr))
        rxs_hi_r <= reg_wdata[HI_W-1:0]; // R13
      if (is_wr(`DCS_OFS_RXE_HI, reg_we, reg_addr))
        rxe_hi_r <= reg_wdata[HI_W-1:0]; // R13
      if (is_wr(`DCS_OFS_DST_HI, reg_we, reg_addr))
        dst_hi_r <= reg_wdata[HI_W-1:0]; // R13
      if (is_wr(`DCS_OFS_DND_HI, reg_we, reg_addr))
        dnd_hi_r <= reg_wdata[HI_W-1:0]; // R13
      if (is_wr(`DCS_OFS_DDS_HI, reg_we, reg_addr))
        dds_hi_r <= reg_wdata[HI_W-1:0]; // R13
    end
  end

  // ---------------------------------------------------------------
  // Result pair
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_lo_r <= `DCS_RST_BYTE;
      res_hi_r <= `DCS_RST_BYTE;
    end
    else if (finish)
    begin
      res_hi_r <= sif.sum[15:8]; // R08
      res_lo_r <= sif.sum[7:0]; // R08
    end
    else
    begin
      if (is_wr(`DCS_OFS_RES_LO, reg_we, reg_addr))
        res_lo_r <= reg_wdata;
      if (is_wr(`DCS_OFS_RES_HI, reg_we, reg_addr))
        res_hi_r <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_r <= `DCS_RST_BYTE;
    else if (reg_re)
    begin
      unique case (reg_addr)
        `DCS_OFS_ENABLE: reg_rdata_r <= enable_r;
        `DCS_OFS_FLAGS: reg_rdata_r <= {2'b00, flag_r, 5'b00000};
        `DCS_OFS_CTRL: reg_rdata_r <= ctrl_r;
        `DCS_OFS_RXS_LO: reg_rdata_r <= rxs_lo_r;
        `DCS_OFS_RXS_HI: reg_rdata_r <= hi_byte(rxs_hi_r);
        `DCS_OFS_RXE_LO: reg_rdata_r <= rxe_lo_r;
        `DCS_OFS_RXE_HI: reg_rdata_r <= hi_byte(rxe_hi_r);
        `DCS_OFS_DST_LO: reg_rdata_r <= dst_lo_r;
        `DCS_OFS_DST_HI: reg_rdata_r <= hi_byte(dst_hi_r);
        `DCS_OFS_DND_LO: reg_rdata_r <= dnd_lo_r;
        `DCS_OFS_DND_HI: reg_rdata_r <= hi_byte(dnd_hi_r);
        `DCS_OFS_DDS_LO: reg_rdata_r <= dds_lo_r;
        `DCS_OFS_DDS_HI: reg_rdata_r <= hi_byte(dds_hi_r);
        `DCS_OFS_RES_LO: reg_rdata_r <= res_lo_r;
        `DCS_OFS_RES_HI: reg_rdata_r <= res_hi_r;
        default: reg_rdata_r <= `DCS_RST_BYTE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Buffer read path, data one clock after request
  // ---------------------------------------------------------------
  dcs_walker #(
    .ADDR_W(ADDR_W)
  ) u_walker (
    .clk(clk),
    .rst_n(rst_n),
    .go(start_go), // R04
    .abort(cancel),
    .start_ptr({dst_hi_r, dst_lo_r}),
    .end_ptr({dnd_hi_r, dnd_lo_r}),
    .rx_start({rxs_hi_r, rxs_lo_r}),
    .rx_end({rxe_hi_r, rxe_lo_r}),
    .addr_r(walk_addr),
    .rd_r(walk_rd),
    .last_r(walk_last)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_vld_r <= 1'b0;
      rd_last_r <= 1'b0;
    end
    else
    begin
      rd_vld_r <= walk_rd && !cancel;
      rd_last_r <= walk_last && !cancel;
    end
  end

  assign sif.byte_vld = rd_vld_r && (state_r == DCS_RUN);
  assign sif.byte_dat = mem_rdata;
  assign sif.byte_last = rd_last_r;
  assign sif.init = start_go;
  assign sif.abort = cancel;

  dcs_accum u_accum (
    .clk(clk),
    .rst_n(rst_n),
    .s(sif)
  );

  // ---------------------------------------------------------------
  // Interrupt and status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_n_r <= 1'b1;
    else
      irq_n_r <= !(flag_r && enable_r[`DCS_BIT_DONE_EN] && enable_r[`DCS_BIT_GIE]); // R06
  end

  assign reg_rdata = reg_rdata_r;
  assign mem_addr = walk_addr;
  assign mem_rd = walk_rd; // R07
  assign irq_n = irq_n_r;
  assign busy = ctrl_r[`DCS_BIT_RUN];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_finish;
    finish && !ctrl_wr;
  endsequence

  sequence s_cleared;
    !ctrl_r[`DCS_BIT_RUN] && flag_r;
  endsequence

  a_done_clears_run: assert property (s_finish |=> s_cleared) // R06
    else $error("finish did not clear run and set flag");

  a_irq_gate: assert property ( // R06
    ##1 (irq_n_r == !$past(flag_r && enable_r[5] && enable_r[7])))
    else $error("interrupt output not gated by both enables");

  a_result_load: assert property ( // R08
    finish |=> res_hi_r == $past(sif.sum[15:8]) && res_lo_r == $past(sif.sum[7:0]))
    else $error("result pair not loaded at finish");

  a_flag_sticky: assert property ( // R16
    flag_r && !is_wr(`DCS_OFS_FLAGS, reg_we, reg_addr) |=> flag_r)
    else $error("done flag dropped without host clear");

  a_cancel_flag: assert property ( // R15
    cancel |=> flag_r && state_r == DCS_IDLE ##1 !mem_rd)
    else $error("cancel did not stop and flag");

  a_ptr_stable: assert property ( // R07
    state_r == DCS_RUN && !reg_we |=> $stable({dst_hi_r, dst_lo_r, dnd_hi_r, dnd_lo_r})
      && $stable({dds_hi_r, dds_lo_r}))
    else $error("pointer changed during operation");

  a_start_run: assert property ( // R05
    start_go |=> state_r == DCS_RUN ##1 (mem_rd && mem_addr == $past({dst_hi_r, dst_lo_r}, 2)))
    else $error("start did not begin reading at start pointer");

  a_hi_zero: assert property ( // R13
    reg_re && reg_addr == `DCS_OFS_DND_HI |=> reg_rdata_r[7:HI_W] == '0)
    else $error("unused pointer bits read nonzero");

endmodule

// *** verification/dcs_mem_model.sv ***
module dcs_mem_model
(
  input wire logic clk,
  input wire logic [12:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:8191];

  initial
  begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 8192; i++)
      mem[i] = i[7:0] ^ {i[12:8], 3'h5};
  end

  // --------------------------------
  // Byte one cycle after request
  // --------------------------------
  // Undriven cycles toggle so a stale byte never looks valid
  always @(posedge clk)
  begin
    if (mem_rd)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule

// *** verification/dcs_top_tb_top.sv ***
`include "dcs_cfg.svh"

module dcs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dcs_pkg::*;
  logic clk, rst_n, reg_we, reg_re, mem_rd, irq_n, busy;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mem_rdata;
  logic [12:0] mem_addr;
  int n_mismatch, num_checks, c3, c5;
  logic [15:0] sv;

  dcs_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .irq_n(irq_n), .busy(busy));
  dcs_mem_model mm (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata));

  always #4 clk = ~clk;

  // --------------------------------
  // Access tasks
  // --------------------------------
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
  endtask

  task rd(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clk);
    reg_re = 1'b0;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  task ptr(input logic [4:0] lo, input logic [12:0] v);
    wr(lo, v[7:0]);
    wr(lo + 5'h01, {3'b000, v[12:8]});
  endtask

  function automatic logic [15:0] exp_sum(input logic [12:0] s, e, rs, re);
    logic [12:0] a;
    logic [15:0] acc, w;
    logic [16:0] t;
    logic hi;
    a = s;
    acc = 16'h0000;
    w = 16'h0000;
    hi = 1'b1;
    for (int i = 0; i < 9000; i++)
    begin
      if (hi)
        w = {mm.mem[a], 8'h00};
      else
        w[7:0] = mm.mem[a];
      if (!hi || a == e)
      begin
        t = {1'b0, acc} + {1'b0, w};
        acc = t[15:0] + {15'h0000, t[16]};
      end
      hi = !hi;
      if (a == e)
        break;
      a = (a == re) ? rs : a + 13'h0001;
    end
    return ~acc;
  endfunction

  task setup(input logic [12:0] s, e, rs, re);
    ptr(`DCS_OFS_RXS_LO, rs);
    ptr(`DCS_OFS_RXE_LO, re);
    ptr(`DCS_OFS_DST_LO, s);
    ptr(`DCS_OFS_DND_LO, e);
    ptr(`DCS_OFS_DDS_LO, 13'h1ABC);
  endtask

  // Pointers stay untouched while running
  task csum(input logic [12:0] s, e, rs, re, output int cyc);
    logic [15:0] x;
    x = exp_sum(s, e, rs, re);
    setup(s, e, rs, re);
    wr(`DCS_OFS_CTRL, 8'h30);
    cyc = 0;
    while (busy !== 1'b0 && cyc < 3000)
    begin
      @(negedge clk);
      cyc++;
    end
    chk({15'h0000, busy}, 16'h0000);
    rd(`DCS_OFS_RES_HI, x[15:8]);
    rd(`DCS_OFS_RES_LO, x[7:0]);
    rd(`DCS_OFS_CTRL, 8'h10);
    rd(`DCS_OFS_FLAGS, 8'h20);
    rd(`DCS_OFS_DST_LO, s[7:0]);
    rd(`DCS_OFS_DND_HI, {3'b000, e[12:8]});
    rd(`DCS_OFS_DDS_LO, 8'hBC);
    rd(`DCS_OFS_DDS_HI, 8'h1A);
  endtask

  task results;
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results;
  end

  // --------------------------------
  // Test sequence
  // --------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk({busy, irq_n}, 16'h0001);
    rd(`DCS_OFS_RES_LO, 8'h00);
    rd(`DCS_OFS_FLAGS, 8'h00);
    rd(`DCS_OFS_CTRL, 8'h00);
    wr(`DCS_OFS_DDS_HI, 8'hFF);
    rd(`DCS_OFS_DDS_HI, 8'h1F);
    wr(`DCS_OFS_RXE_HI, 8'hFF);
    rd(`DCS_OFS_RXE_HI, 8'h1F);
    rd(5'h1F, 8'h00);
    // Run without checksum select must not read the buffer
    wr(`DCS_OFS_CTRL, 8'h20);
    repeat (3) @(negedge clk);
    chk({15'h0000, mem_rd}, 16'h0000);
    wr(`DCS_OFS_CTRL, 8'h00);
    mm.mem[256] = 8'h89;
    mm.mem[257] = 8'hAB;
    mm.mem[258] = 8'hCD;
    csum(13'h0100, 13'h0102, 13'h0000, 13'h1FFF, c3);
    rd(`DCS_OFS_RES_HI, 8'hA9);
    wr(`DCS_OFS_FLAGS, 8'h00);
    rd(`DCS_OFS_FLAGS, 8'h00);
    csum(13'h0100, 13'h0104, 13'h0000, 13'h1FFF, c5);
    chk(16'(c5 - c3), 16'h0002);
    // Embedded field at 0104..0105: save, zero, recompute, compare
    mm.mem[260] = 8'h00;
    mm.mem[261] = 8'h00;
    {mm.mem[260], mm.mem[261]} = exp_sum(13'h0100, 13'h0105, 13'h0000, 13'h1FFF);
    sv = {mm.mem[260], mm.mem[261]};
    mm.mem[260] = 8'h00;
    mm.mem[261] = 8'h00;
    csum(13'h0100, 13'h0105, 13'h0000, 13'h1FFF, c3);
    rd(`DCS_OFS_RES_HI, sv[15:8]);
    rd(`DCS_OFS_RES_LO, sv[7:0]);
    // Enable completion interrupt before starting
    wr(`DCS_OFS_ENABLE, 8'hA0);
    wr(`DCS_OFS_FLAGS, 8'h00);
    csum(13'h001E, 13'h0011, 13'h0010, 13'h001F, c3);
    repeat (2) @(negedge clk);
    chk({15'h0000, irq_n}, 16'h0000);
    wr(`DCS_OFS_FLAGS, 8'h00);
    repeat (2) @(negedge clk);
    chk({15'h0000, irq_n}, 16'h0001);
    wr(`DCS_OFS_ENABLE, 8'h20);
    rd(`DCS_OFS_ENABLE, 8'h20);
    csum(13'h0055, 13'h0055, 13'h0000, 13'h1FFF, c3);
    repeat (2) @(negedge clk);
    chk({15'h0000, irq_n}, 16'h0001);
    wr(`DCS_OFS_FLAGS, 8'h00);
    setup(13'h0000, 13'h01FF, 13'h0000, 13'h1FFF);
    wr(`DCS_OFS_CTRL, 8'h30);
    repeat (5) @(negedge clk);
    wr(`DCS_OFS_CTRL, 8'h10);
    repeat (2) @(negedge clk);
    chk({14'h0000, busy, mem_rd}, 16'h0000);
    rd(`DCS_OFS_FLAGS, 8'h20);
    rd(`DCS_OFS_RES_HI, 8'(exp_sum(13'h0055, 13'h0055, 13'h0000, 13'h1FFF) >> 8));
    rd(`DCS_OFS_DND_LO, 8'hFF);
    repeat (10) @(negedge clk);
    rd(`DCS_OFS_FLAGS, 8'h20);
    results;
  end
endmodule
